// ==== rtl/wcu_pkg.sv ====
// Purpose: shared constants for the wide counter unit
// Assumes: 32-bit AHB-Lite register bus, one 10 MHz core clock
// Notes: every offset and field position lives here, with the control, count, buffer and read-data reset values

package wcu_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_LOW = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0C;

    // ****************************************************************
    // counter_control field positions
    // ****************************************************************
    localparam int BIT_RUN = 0;
    localparam int BIT_CSEL = 1;
    localparam int BIT_SYNC_DIS = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_PRE_LO = 4;
    localparam int BIT_PRE_HI = 5;
    localparam int BIT_SYSCLK_STAT = 6;
    localparam int BIT_WIDE = 7;

    // overflow flag register fields
    localparam int BIT_OVF_FLAG = 0;
    localparam int BIT_OVF_IE = 1;

    // ****************************************************************
    // reset values and widths
    // ****************************************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] HIGH_BUF_RESET = 8'h00;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam int PRE_W = 3;

    // ****************************************************************
    // timing: instruction cycle is four core clocks
    // ****************************************************************
    localparam int FOSC_PER_INST = 4;
    localparam logic [1:0] INST_LAST = 2'(FOSC_PER_INST - 1);

    // synchronised input lanes
    localparam int N_IN = 4;
    localparam int IN_EXT_PIN = 0;
    localparam int IN_XTAL_PIN = 1;
    localparam int IN_OSC_CLK = 2;
    localparam int IN_SYSCLK = 3;

    // ahb transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : wcu_pkg

// ==== rtl/wcu_core_if.sv ====
// Purpose: carrier between the counter top and its helper modules
// Assumes: all members but raw live on the core clock; raw is unsynchronised
// Notes: raw inputs go in, synchronised levels and edges come back

`timescale 1ns/1ns

interface wcu_core_if;
    import wcu_pkg::*;
    logic [N_IN-1:0] raw;
    logic [N_IN-1:0] lvl;
    logic [N_IN-1:0] rise;
    logic tick_in;
    logic pre_clr;
    logic [1:0] pre_sel;
    logic tick_out;

    modport sync (input raw, output lvl, output rise);
    modport pre (input tick_in, input pre_clr, input pre_sel,
        output tick_out);
    modport core (output raw, output tick_in, output pre_clr,
        output pre_sel, input lvl, input rise, input tick_out);
endinterface : wcu_core_if

// ==== rtl/wcu_sync.sv ====
// Purpose: two-flop synchronisers with rising edge detect
// Assumes: raw inputs may change at any time
// Notes: first flop feeds only the second flop

`timescale 1ns/1ns

module wcu_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // carrier
    wcu_core_if.sync bus
);
    import wcu_pkg::*;

    logic [N_IN-1:0] meta;
    logic [N_IN-1:0] stage;
    logic [N_IN-1:0] prev;

    // one synchroniser per input lane
    genvar g;
    generate
        for (g = 0; g < N_IN; g++) begin : g_lane
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta[g] <= 1'b0;
                    stage[g] <= 1'b0;
                    prev[g] <= 1'b0;
                end else begin
                    meta[g] <= bus.raw[g];
                    stage[g] <= meta[g];
                    prev[g] <= stage[g];
                end
            end
            assign bus.lvl[g] = stage[g];
            // edge from the second and third flops only
            assign bus.rise[g] = stage[g] & ~prev[g];
        end
    endgenerate

endmodule : wcu_sync

// ==== rtl/wcu_prescale.sv ====
// Purpose: 1:1 to 1:8 input prescaler
// Assumes: tick_in is a one-cycle pulse
// Notes: clear restarts the ratio count from zero

`timescale 1ns/1ns

module wcu_prescale (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // carrier
    wcu_core_if.pre bus
);
    import wcu_pkg::*;

    logic [PRE_W-1:0] cnt;
    logic [PRE_W-1:0] last;

    // ratio minus one: 0, 1, 3, 7
    assign last = PRE_W'((4'h1 << bus.pre_sel) - 4'h1);
    assign bus.tick_out = bus.tick_in && (cnt == last) && !bus.pre_clr;

    // clear wins so a low-byte write restarts cleanly
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= '0;
        end else if (bus.pre_clr) begin
            cnt <= '0;
        end else if (bus.tick_in) begin
            cnt <= (cnt >= last) ? '0 : PRE_W'(cnt + 1'b1);
        end
    end

endmodule : wcu_prescale

// ==== rtl/wcu_top.sv ====
// Purpose: 16-bit timer/counter with crystal oscillator control
// Assumes: AHB-Lite slave, 32-bit data, word access only
// Notes: reads take one wait state, writes none

`timescale 1ns/1ns

module wcu_top (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // shared port pins: bit 0 count clock, bit 1 crystal input
    input wire logic [1:0] PIN_I,
    output logic [1:0] PIN_O,
    output logic [1:0] PIN_OE_O,
    input wire logic [1:0] PORT_DIR_I,
    input wire logic [1:0] PORT_OUT_I,
    output logic [1:0] PORT_READ_O,
    // crystal oscillator cell
    input wire logic OSC_CLK_I,
    output logic XTAL_EN_O,
    // system and event inputs
    input wire logic SYSCLK_FROM_OSC_I,
    input wire logic SLEEP_I,
    input wire logic SPECIAL_RESET_I,
    // overflow request
    output logic OVF_IRQ_O
);
    import wcu_pkg::*;

    // ****************************************************************
    // helper instances
    // ****************************************************************
    wcu_core_if cif ();

    wcu_sync u_sync (
        .clk_i(MCLK_I),
        .nrst_i(NRST_I),
        .bus(cif.sync)
    );

    wcu_prescale u_pre (
        .clk_i(MCLK_I),
        .nrst_i(NRST_I),
        .bus(cif.pre)
    );

    assign cif.raw[IN_EXT_PIN] = PIN_I[0];
    assign cif.raw[IN_XTAL_PIN] = PIN_I[1];
    assign cif.raw[IN_OSC_CLK] = OSC_CLK_I;
    assign cif.raw[IN_SYSCLK] = SYSCLK_FROM_OSC_I;

    // ****************************************************************
    // state
    // ****************************************************************
    logic count_run_enable;
    logic clock_source_select;
    logic external_sync_disable;
    logic crystal_osc_enable;
    logic [1:0] input_prescale_select;
    logic wide_access_mode;
    logic [15:0] count;
    logic [7:0] high_buf;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] inst_cnt;
    logic inst_en;
    logic sync_pend;

    // bus pipeline
    logic wr_pend;
    logic rd_pend;
    logic [7:0] ph_addr;
    logic addr_ok;
    logic [7:0] wbyte;

    // ****************************************************************
    // bus address phase
    // ****************************************************************
    // only word transfers are accepted; others pass as no-ops
    assign addr_ok = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ)
        && (HSIZE_I == 3'h2);
    assign wbyte = HWDATA_I[7:0];

    // capture address for the data phase
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            if (HREADY_I || rd_pend) begin
                wr_pend <= addr_ok && HWRITE_I;
                rd_pend <= addr_ok && !HWRITE_I;
            end
            if (addr_ok) begin
                ph_addr <= HADDR_I[7:0];
            end
        end
    end

    // a read waits one cycle so a preceding write is visible
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= !(addr_ok && !HWRITE_I);
            HRESP_O <= 1'b0;
        end
    end

    // write strobes, valid in the write data phase; rd_low in the read data phase
    logic wr_ctl;
    logic wr_low;
    logic wr_high;
    logic wr_flag;
    logic rd_low;
    assign wr_ctl = wr_pend && (ph_addr == OFS_CONTROL);
    assign wr_low = wr_pend && (ph_addr == OFS_LOW);
    assign wr_high = wr_pend && (ph_addr == OFS_HIGH);
    assign wr_flag = wr_pend && (ph_addr == OFS_FLAG);
    assign rd_low = rd_pend && (ph_addr == OFS_LOW);

    // ****************************************************************
    // control register
    // ****************************************************************
    // all control bits zero from reset
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            count_run_enable <= CONTROL_RESET[BIT_RUN];
            clock_source_select <= CONTROL_RESET[BIT_CSEL];
            external_sync_disable <= CONTROL_RESET[BIT_SYNC_DIS];
            crystal_osc_enable <= CONTROL_RESET[BIT_OSC_EN];
            input_prescale_select <= CONTROL_RESET[BIT_PRE_HI:BIT_PRE_LO];
            wide_access_mode <= CONTROL_RESET[BIT_WIDE];
        end else if (wr_ctl) begin
            count_run_enable <= wbyte[BIT_RUN];
            clock_source_select <= wbyte[BIT_CSEL];
            external_sync_disable <= wbyte[BIT_SYNC_DIS];
            crystal_osc_enable <= wbyte[BIT_OSC_EN];
            input_prescale_select <= wbyte[BIT_PRE_HI:BIT_PRE_LO];
            wide_access_mode <= wbyte[BIT_WIDE];
        end
    end

    // ****************************************************************
    // count source selection
    // ****************************************************************
    // instruction cycle enable, one core clock in four
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            inst_cnt <= 2'h0;
        end else begin
            inst_cnt <= (inst_cnt == INST_LAST) ? 2'h0 : inst_cnt + 2'h1;
        end
    end
    assign inst_en = (inst_cnt == INST_LAST);

    // oscillator edges replace the pin when enabled
    logic src_rise;
    assign src_rise = crystal_osc_enable ? cif.rise[IN_OSC_CLK]
        : cif.rise[IN_EXT_PIN];

    // synced mode holds an edge for the next instruction cycle
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sync_pend <= 1'b0;
        end else if (src_rise) begin
            sync_pend <= 1'b1;
        end else if (inst_en && !SLEEP_I) begin
            sync_pend <= 1'b0;
        end
    end

    // input tick to the prescaler; sleep stops the core clock
    // internal source ticks per instruction cycle
    // the unsynchronised path keeps counting while asleep
    logic tick;
    always_comb begin
        tick = 1'b0;
        if (!clock_source_select) begin
            tick = inst_en && !SLEEP_I;
        end else if (external_sync_disable) begin
            tick = src_rise;
        end else begin
            tick = sync_pend && inst_en && !SLEEP_I;
        end
    end

    // prescaler only sees ticks while running
    assign cif.tick_in = tick && count_run_enable;
    // ratio straight from the select field
    assign cif.pre_sel = input_prescale_select;
    // only low-byte writes clear the prescaler
    assign cif.pre_clr = wr_low;

    // ****************************************************************
    // counter, buffer and overflow
    // ****************************************************************
    logic adv;
    logic sp_ok;
    assign adv = cif.tick_out && count_run_enable;
    // special reset is unreliable in asynchronous mode, so it is gated
    assign sp_ok = SPECIAL_RESET_I
        && !(clock_source_select && external_sync_disable);

    // a software write takes priority over the event reset
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            count <= COUNT_RESET;
        end else begin
            if (wr_low) begin
                count[7:0] <= wbyte;
                // high byte loaded from buffer together
                if (wide_access_mode) begin
                    count[15:8] <= high_buf;
                end
            end else if (wr_high && !wide_access_mode) begin
                // byte mode writes the live high byte
                count[15:8] <= wbyte;
            end else if (sp_ok) begin
                count <= COUNT_RESET;
            end else if (adv) begin
                // wraps from all ones to zero
                count <= count + 16'h0001;
            end
        end
    end

    // wide-mode high byte accesses hit only the buffer
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            high_buf <= HIGH_BUF_RESET;
        end else if (wr_high && wide_access_mode) begin
            high_buf <= wbyte;
        end else if (rd_low && wide_access_mode) begin
            // snapshot of the live high byte
            high_buf <= count[15:8];
        end
    end

    // overflow flag; a set in the clear cycle wins
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else begin
            if (adv && !sp_ok && !wr_low && count == COUNT_ALL_ONES
                && !(wr_high && !wide_access_mode)) begin
                overflow_flag <= 1'b1;
            end else if (wr_flag && wbyte[BIT_OVF_FLAG]) begin
                overflow_flag <= 1'b0;
            end
            if (wr_flag) begin
                overflow_irq_enable <= wbyte[BIT_OVF_IE];
            end
        end
    end

    // enable gates the latched flag onto the request
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            OVF_IRQ_O <= 1'b0;
        end else begin
            OVF_IRQ_O <= overflow_flag && overflow_irq_enable;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [7:0] ctl_rd;
    // status bit follows the synchronised clock-source level
    assign ctl_rd = {wide_access_mode, cif.lvl[IN_SYSCLK],
        input_prescale_select, crystal_osc_enable,
        external_sync_disable, clock_source_select, count_run_enable};

    // high-byte address meaning depends on access mode
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            HRDATA_O <= RDATA_RESET;
        end else if (rd_pend) begin
            unique case (ph_addr)
                OFS_CONTROL: HRDATA_O <= {24'h0, ctl_rd};
                OFS_LOW: HRDATA_O <= {24'h0, count[7:0]};
                OFS_HIGH: HRDATA_O <= {24'h0,
                    wide_access_mode ? high_buf : count[15:8]};
                OFS_FLAG: HRDATA_O <= {30'h0, overflow_irq_enable,
                    overflow_flag};
                default: HRDATA_O <= RDATA_RESET;
            endcase
        end
    end

    // ****************************************************************
    // pins and oscillator
    // ****************************************************************
    // running counter turns both pins to inputs, reads zero
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PIN_O <= 2'h0;
            PIN_OE_O <= 2'h0;
            PORT_READ_O <= 2'h0;
        end else begin
            PIN_O <= PORT_OUT_I;
            PIN_OE_O <= count_run_enable ? 2'h0 : ~PORT_DIR_I;
            PORT_READ_O <= count_run_enable ? 2'h0
                : {cif.lvl[IN_XTAL_PIN], cif.lvl[IN_EXT_PIN]};
        end
    end

    // oscillator power follows its enable bit alone
    // sleep has no say, so it keeps running when idle
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            XTAL_EN_O <= 1'b0;
        end else begin
            XTAL_EN_O <= crystal_osc_enable;
        end
    end

endmodule : wcu_top

// ==== dv/wcu_cpu.sv ====
// Purpose: core-side bus master for the counter registers
// Assumes: one slave whose hreadyout is the bus hready
// Notes: single word transfers with an idle cycle between them

`timescale 1ns/1ns

module wcu_cpu (
    // clock
    input wire logic clk_i,
    // requests
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o,
    // answers
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i
);
    import wcu_pkg::*;
    // ****
    // bus master
    // ****
    // bus idle from time zero
    initial begin
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hwdata_o = 32'h0;
    end

    // each phase holds until hready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        haddr_o <= {24'h0, a};
        htrans_o <= HTRANS_NONSEQ;
        hwrite_o <= w;
        do @(posedge clk_i); while (!hready_i);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_i); while (!hready_i);
        r = hrdata_i;
    endtask : xfer
endmodule : wcu_cpu

// ==== dv/wcu_assertions.sv ====
// Purpose: port checks for the wide counter unit
// Assumes: one clock, async active-low reset
// Notes: run, osc and irq-enable bits are shadowed from bus writes

`timescale 1ns/1ns

module wcu_assertions
    import wcu_pkg::*;
(
    // clock, reset and bus
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // pins and status
    input wire logic [1:0] PIN_OE_O,
    input wire logic [1:0] PORT_READ_O,
    input wire logic XTAL_EN_O,
    input wire logic OVF_IRQ_O
);
    // ****
    // shadow state
    // ****
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);
    logic take, wr_pend, run_q, osc_q, ie_q;
    logic [7:0] wr_adr;
    assign take = HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ
        && HSIZE_I == 3'h2;
    // bits land at the end of the data phase, as in the design
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wr_pend <= 1'b0;
            wr_adr <= 8'h00;
            run_q <= 1'b0;
            osc_q <= 1'b0;
            ie_q <= 1'b0;
        end else begin
            wr_pend <= take && HWRITE_I;
            wr_adr <= HADDR_I[7:0];
            if (wr_pend && wr_adr == OFS_CONTROL) begin
                run_q <= HWDATA_I[BIT_RUN];
                osc_q <= HWDATA_I[BIT_OSC_EN];
            end
            if (wr_pend && wr_adr == OFS_FLAG) begin
                ie_q <= HWDATA_I[BIT_OVF_IE];
            end
        end
    end
    // ****
    // properties
    // ****
    property p_resp_okay; HRESP_O == 1'b0; endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("bus error response");
    property p_rd_wait; take && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    property p_wr_nowait; take && HWRITE_I |=> HREADYOUT_O; endproperty
    a_wr_nowait: assert property (p_wr_nowait)
        else $error("write stalled");
    property p_byte_data; HRDATA_O[31:8] == 24'h0; endproperty
    a_byte_data: assert property (p_byte_data)
        else $error("read data above byte");
    property p_pins_run; run_q && $past(run_q) |->
        PIN_OE_O == 2'b00 && PORT_READ_O == 2'b00; endproperty
    a_pins_run: assert property (p_pins_run)
        else $error("pins not inputs while running");
    property p_xtal; osc_q == $past(osc_q) |-> XTAL_EN_O == osc_q;
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("oscillator enable mismatch");
    property p_irq_mask; !ie_q && !$past(ie_q) |-> !OVF_IRQ_O; endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked overflow request");
    property p_rst_quiet; $rose(NRST_I) |-> HREADYOUT_O && !OVF_IRQ_O
        && !XTAL_EN_O && PIN_OE_O == 2'b00; endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not idle after reset");
endmodule : wcu_assertions

bind wcu_top wcu_assertions u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
    .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O), .PIN_OE_O(PIN_OE_O), .PORT_READ_O(PORT_READ_O),
    .XTAL_EN_O(XTAL_EN_O), .OVF_IRQ_O(OVF_IRQ_O));

// ==== dv/tb_wcu_top.sv ====
// Purpose: self-checking bench for the wide counter unit
// Assumes: 10 MHz core clock, counts made from pin and osc edges and internal ticks
// Notes: a bus monitor checks read data in issue order

`timescale 1ns/1ns

module tb_wcu_top;
    import wcu_pkg::*;
    // ****
    // signals and instances
    // ****
    logic MCLK_I = 1'b0;
    logic NRST_I = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, lo, hi, r;
    logic [1:0] htrans, oe, prd, po, pdir = 2'h0, pout = 2'h0, pin = 2'h0;
    logic hwrite, hready, hresp, ovf, xtal, rd_dp = 1'b0;
    logic osc = 1'b0, sclk = 1'b0, slp = 1'b0, spr = 1'b0;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    wcu_top u_dut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .PIN_I(pin), .PIN_O(po), .PIN_OE_O(oe), .PORT_DIR_I(pdir),
        .PORT_OUT_I(pout), .PORT_READ_O(prd), .OSC_CLK_I(osc),
        .XTAL_EN_O(xtal), .SYSCLK_FROM_OSC_I(sclk), .SLEEP_I(slp),
        .SPECIAL_RESET_I(spr), .OVF_IRQ_O(ovf));
    wcu_cpu u_cpu (.clk_i(MCLK_I), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hwdata_o(hwdata), .hready_i(hready),
        .hrdata_i(hrdata));

    // free-running core clock
    initial begin
        forever #50 MCLK_I = ~MCLK_I;
    end

    task automatic check(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic results;
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_cpu.xfer(1'b1, a, d, x);
    endtask : wr

    // note the expectation first; the monitor compares it
    task automatic rd(input string n, input logic [7:0] a, logic [31:0] e);
        logic [31:0] x;
        exp_q.push_back(e);
        nm_q.push_back(n);
        u_cpu.xfer(1'b0, a, $urandom, x);
    endtask : rd

    // slow pulses on the count pin or the oscillator; tail lets sync land
    task automatic edges(input int n, input bit o);
        repeat (n) begin
            osc <= o;
            pin[0] <= !o;
            repeat (4) @(posedge MCLK_I);
            osc <= 1'b0;
            pin[0] <= 1'b0;
            repeat (4) @(posedge MCLK_I);
        end
        repeat (6) @(posedge MCLK_I);
    endtask : edges

    // read data phases complete when hready is seen high
    always @(posedge MCLK_I) begin
        if (rd_dp && hready) begin
            check(nm_q.pop_front(), hrdata, exp_q.pop_front());
            rd_dp <= 1'b0;
        end
        if (htrans == HTRANS_NONSEQ && hready && !hwrite) begin
            rd_dp <= 1'b1;
        end
    end

    // hang guard, far above the few thousand cycles needed
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end

    // ****
    // scenarios
    // ****
    initial begin
        r = $urandom(70);
        pdir <= 2'($urandom);
        pout <= 2'($urandom);
        pin[1] <= 1'($urandom);
        repeat (2) @(posedge MCLK_I);
        NRST_I <= 1'b1;
        rd("ctl", OFS_CONTROL, 0);
        rd("flag", OFS_FLAG, 0);
        wr(OFS_CONTROL, 32'h40);
        rd("stat0", OFS_CONTROL, 0);
        sclk <= 1'b1;
        repeat (4) @(posedge MCLK_I);
        rd("stat1", OFS_CONTROL, 32'h40);
        sclk <= 1'b0;
        lo = $urandom;
        hi = $urandom;
        wr(OFS_LOW, lo);
        wr(OFS_HIGH, hi);
        rd("lo", OFS_LOW, lo & 32'hFF);
        rd("hi", OFS_HIGH, hi & 32'hFF);
        wr(OFS_CONTROL, 32'h80);
        wr(OFS_HIGH, 32'h5A);
        rd("hbuf", OFS_HIGH, 32'h5A);
        wr(OFS_CONTROL, 0);
        rd("hlive", OFS_HIGH, hi & 32'hFF);
        wr(OFS_CONTROL, 32'h80);
        rd("lsnap", OFS_LOW, lo & 32'hFF);
        rd("hsnap", OFS_HIGH, hi & 32'hFF);
        wr(OFS_HIGH, 32'hC3);
        wr(OFS_LOW, 32'h3C);
        wr(OFS_CONTROL, 0);
        rd("hload", OFS_HIGH, 32'hC3);
        // event reset held across a low write: the write must win
        spr <= 1'b1;
        wr(OFS_LOW, 32'h77);
        spr <= 1'b0;
        rd("swin", OFS_LOW, 32'h77);
        rd("sphi", OFS_HIGH, 0);
        // each prescale ratio on async pin counting, then stopped
        for (int p = 0; p < 4; p++) begin
            wr(OFS_LOW, 0);
            wr(OFS_HIGH, 0);
            wr(OFS_CONTROL, 32'h07 | (p << 4));
            edges(9, 1'b0);
            wr(OFS_CONTROL, 32'h06);
            edges(3, 1'b0);
            rd("cnt", OFS_LOW, 32'(9 >> p));
        end
        check("oe_off", {30'h0, oe}, {30'h0, ~pdir});
        check("prd", {30'h0, prd}, {30'h0, pin[1], 1'b0});
        check("pout", {30'h0, po}, {30'h0, pout});
        // high write keeps the 1:8 prescaler phase, low write clears it
        wr(OFS_LOW, 0);
        wr(OFS_CONTROL, 32'h37);
        edges(4, 1'b0);
        wr(OFS_HIGH, 0);
        edges(4, 1'b0);
        rd("pkeep", OFS_LOW, 1);
        edges(4, 1'b0);
        wr(OFS_LOW, 0);
        edges(4, 1'b0);
        rd("pclr", OFS_LOW, 0);
        wr(OFS_LOW, 0);
        wr(OFS_CONTROL, 32'h03);
        edges(5, 1'b0);
        rd("sync", OFS_LOW, 5);
        slp <= 1'b1;
        wr(OFS_CONTROL, 32'h0E);
        repeat (20) @(posedge MCLK_I);
        check("xtal", {31'h0, xtal}, 1);
        wr(OFS_LOW, 0);
        wr(OFS_CONTROL, 32'h0F);
        edges(6, 1'b1);
        rd("osc", OFS_LOW, 6);
        wr(OFS_CONTROL, 32'h03);
        edges(5, 1'b0);
        rd("ssync", OFS_LOW, 6);
        wr(OFS_CONTROL, 0);
        slp <= 1'b0;
        // internal ticks: 1024 clocks must carry into the high byte once
        wr(OFS_LOW, 32'h80);
        wr(OFS_HIGH, 0);
        wr(OFS_CONTROL, 1);
        repeat (1024) @(posedge MCLK_I);
        wr(OFS_CONTROL, 0);
        rd("ihi", OFS_HIGH, 1);
        wr(OFS_FLAG, 3);
        wr(OFS_HIGH, 32'hFF);
        wr(OFS_LOW, 32'hFE);
        wr(OFS_CONTROL, 32'h07);
        edges(1, 1'b0);
        check("irq0", {31'h0, ovf}, 0);
        edges(1, 1'b0);
        check("irq1", {31'h0, ovf}, 1);
        wr(OFS_CONTROL, 0);
        rd("wrap", OFS_HIGH, 0);
        rd("flg", OFS_FLAG, 3);
        wr(OFS_FLAG, 1);
        rd("flg0", OFS_FLAG, 0);
        repeat (2) @(posedge MCLK_I);
        results();
    end
endmodule : tb_wcu_top
